// ==== src/pti_pkg.sv ====
// constants shared by the peripheral task/event register interface.
// assumes a 4 KB register window per peripheral, word aligned accesses.
package pti_pkg;

	// address window and peripheral numbering
	localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
	localparam logic [31:0] BLOCK_SIZE  = 32'h0000_1000;
	localparam int          ADDR_W      = 12;
	localparam int          NUM_SLOTS   = 32;

	// register offsets inside the window
	localparam logic [11:0] TASK_LO_OFS   = 12'h000;
	localparam logic [11:0] TASK_HI_OFS   = 12'h07c;
	localparam logic [11:0] EVT_LO_OFS    = 12'h100;
	localparam logic [11:0] EVT_HI_OFS    = 12'h17c;
	localparam logic [11:0] LINK_EN_OFS   = 12'h200;
	localparam logic [11:0] IRQ_MASK_OFS  = 12'h300;
	localparam logic [11:0] IRQ_SET_OFS   = 12'h304;
	localparam logic [11:0] IRQ_CLR_OFS   = 12'h308;
	localparam logic [11:0] GEN_LO_OFS    = 12'h400;
	localparam logic [11:0] GEN_HI_OFS    = 12'h7fc;

	// field positions and reset values
	localparam int          FLAG_BIT      = 0;
	localparam logic [31:0] LINK_EN_RST   = 32'h0000_0000;
	localparam logic [31:0] IRQ_MASK_RST  = 32'h0000_0000;
	localparam logic [31:0] EVT_FLAG_RST  = 32'h0000_0000;

	// true when a word address lies inside [lo, hi]
	function automatic logic in_range(input logic [11:0] a,
		input logic [11:0] lo, input logic [11:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// slot number of a word inside a 32-word group
	function automatic logic [4:0] slot_of(input logic [11:0] a);
		slot_of = a[6:2];
	endfunction

endpackage

// ==== src/pti_core.sv ====
// register interface shared by every peripheral: tasks, sticky events,
// event-to-task links and the interrupt mask with set/clear companions.
// assumes a simple single-cycle register port driven synchronously to
// clk_in, and task/event toggle signals synchronous to clk_in.
`timescale 1ns/1ps

module pti_core #(
	parameter logic [31:0] BASE_ADDR = 32'h4000_0000
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        reg_sel_in,
	input  wire logic        reg_wr_in,
	input  wire logic [11:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	output logic             reg_ack_out,
	input  wire logic [31:0] task_sig_in,
	input  wire logic [31:0] evt_sig_in,
	output logic      [31:0] task_trig_out,
	output logic      [31:0] evt_gen_out,
	output logic             irq_out,
	output logic      [4:0]  irq_num_out,
	output logic             cfg_wr_out,
	output logic      [11:0] cfg_addr_out,
	output logic      [31:0] cfg_wdata_out,
	input  wire logic [31:0] cfg_rdata_in
);

	// identifier follows the base address of the window
	localparam logic [31:0] PERIPH_ID =
		(BASE_ADDR - pti_pkg::PERIPH_BASE) / pti_pkg::BLOCK_SIZE;

	// register port timing, as the processor side sees it:
	//  edge 0: reg_sel_in high with reg_wr_in, address and data standing
	//  edge 1: reg_ack_out high for one cycle; read data on reg_rdata_out
	//  read data then holds until the next read is taken
	//  back-to-back accesses on every edge are allowed
	// writes land at edge 0, so a read at edge 1 already sees them.
	//
	// reset sequence:
	//  rst_b_in low clears everything at once, without a clock
	//  the internal copy rises two edges after rst_b_in rises
	//  the first edge after that only loads the toggle history
	//  toggles count from the second edge onward
	// a bus access before the internal copy rises is answered by nothing.
	//
	// event path, for event n:
	//  edge 0: evt_sig_in[n] has changed level since the last edge
	//  edge 1: evt_gen_out[n] pulses, the flag reads one,
	//          task n pulses as well when link n is enabled
	//  edge 2: irq_out rises when mask bit n is set
	// the pulse repeats on every toggle, set flag or not, so a link or a
	// consumer outside never misses an event because software was slow.
	//
	// task path, for task n:
	//  edge 0: a write of one in bit 0 to the task word, or a change of
	//          task_sig_in[n]
	//  edge 1: task_trig_out[n] pulses for one cycle
	// software and hardware triggers in one cycle merge into one pulse;
	// the peripheral cannot tell them apart, which is harmless because a
	// task is an edge, not a count.
	//
	// clear against set: a toggle in the very cycle of a clearing write
	// keeps the flag set, so an event is never lost between the read that
	// found the source and the write that acknowledged it.
	//
	// generic region: strobe, address and data go out combinationally in
	// the write cycle; the peripheral's read data is sampled at the read
	// edge and appears with the ack.

	// true for the word of the link enable register
	function automatic logic hit_link(input logic [11:0] a);
		hit_link = (a == pti_pkg::LINK_EN_OFS);
	endfunction

	// true for the main interrupt mask word
	function automatic logic hit_mask(input logic [11:0] a);
		hit_mask = (a == pti_pkg::IRQ_MASK_OFS);
	endfunction

	// true for the set companion of the interrupt mask
	function automatic logic hit_set(input logic [11:0] a);
		hit_set = (a == pti_pkg::IRQ_SET_OFS);
	endfunction

	// true for the clear companion of the interrupt mask
	function automatic logic hit_clr(input logic [11:0] a);
		hit_clr = (a == pti_pkg::IRQ_CLR_OFS);
	endfunction

	// true for any of the three words of the mask group
	function automatic logic hit_mask_grp(input logic [11:0] a);
		hit_mask_grp = hit_mask(a) || hit_set(a) || hit_clr(a);
	endfunction

	// reset synchroniser, toggle history, event flags, link enables and interrupt mask

	logic        rst_meta_r;
	logic        rst_sync_r;
	logic        primed_r;
	logic [31:0] task_prev_r;
	logic [31:0] evt_prev_r;
	logic [31:0] evt_flag_r;
	logic [31:0] link_en_r;
	logic [31:0] irq_mask_r;
	// output pulses, interrupt level and held read data
	logic [31:0] task_trig_r;
	logic [31:0] evt_gen_r;
	logic        irq_r;
	logic [31:0] rdata_r;
	logic        ack_r;

	// decode and next values, all combinational
	logic [11:0] waddr;
	logic        wr_acc;
	logic        is_task;
	logic        is_evt;
	logic        is_gen;
	logic [31:0] slot_bit;
	logic [31:0] task_tog;
	logic [31:0] evt_tog;
	logic [31:0] sw_task;
	logic [31:0] evt_clr;
	logic [31:0] rdata_nxt;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// word address decode; low address bits are ignored
	always_comb begin
		waddr   = {reg_addr_in[11:2], 2'b00};
		wr_acc  = reg_sel_in & reg_wr_in;
		is_task = pti_pkg::in_range(waddr, pti_pkg::TASK_LO_OFS,
			pti_pkg::TASK_HI_OFS);
		is_evt  = pti_pkg::in_range(waddr, pti_pkg::EVT_LO_OFS,
			pti_pkg::EVT_HI_OFS);
		is_gen  = pti_pkg::in_range(waddr, pti_pkg::GEN_LO_OFS,
			pti_pkg::GEN_HI_OFS);
		slot_bit = 32'h0000_0001 << pti_pkg::slot_of(waddr);
	end

	// previous levels of toggle inputs; the first cycle after reset only
	// loads them, so a signal idling high does not fire a false toggle
	always_ff @(posedge clk_in or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			primed_r    <= 1'b0;
			task_prev_r <= 32'h0000_0000;
			evt_prev_r  <= 32'h0000_0000;
		end else begin
			primed_r    <= 1'b1;
			task_prev_r <= task_sig_in;
			evt_prev_r  <= evt_sig_in;
		end
	end

	// toggle detection and software task/event writes
	always_comb begin
		task_tog = primed_r ? (task_sig_in ^ task_prev_r) : 32'h0000_0000;
		evt_tog  = primed_r ? (evt_sig_in ^ evt_prev_r) : 32'h0000_0000;
		// only a one in the flag bit starts a task
		sw_task  = (wr_acc && is_task && reg_wdata_in[pti_pkg::FLAG_BIT])
			? slot_bit : 32'h0000_0000;
		evt_clr  = (wr_acc && is_evt && !reg_wdata_in[pti_pkg::FLAG_BIT])
			? slot_bit : 32'h0000_0000;
	end

	// sticky event flags; a new event in the clearing cycle is kept
	always_ff @(posedge clk_in or negedge rst_sync_r) begin
		if (!rst_sync_r)
			evt_flag_r <= pti_pkg::EVT_FLAG_RST;
		else
			evt_flag_r <= (evt_flag_r & ~evt_clr) | evt_tog;
	end

	// event pulses go out every time, whatever the flag holds
	always_ff @(posedge clk_in or negedge rst_sync_r) begin
		if (!rst_sync_r)
			evt_gen_r <= 32'h0000_0000;
		else
			evt_gen_r <= evt_tog;
	end

	// link enables; link n wires event n to task n and cannot be moved
	always_ff @(posedge clk_in or negedge rst_sync_r) begin
		if (!rst_sync_r)
			link_en_r <= pti_pkg::LINK_EN_RST;
		else if (wr_acc && hit_link(waddr))
			link_en_r <= reg_wdata_in;
	end

	// task pulses from software, task signals and enabled links
	always_ff @(posedge clk_in or negedge rst_sync_r) begin
		if (!rst_sync_r)
			task_trig_r <= 32'h0000_0000;
		else
			task_trig_r <= sw_task | task_tog
				| (evt_tog & link_en_r);
	end

	// interrupt mask with set and clear companions
	always_ff @(posedge clk_in or negedge rst_sync_r) begin
		if (!rst_sync_r)
			irq_mask_r <= pti_pkg::IRQ_MASK_RST;
		else if (wr_acc && hit_mask(waddr))
			irq_mask_r <= reg_wdata_in;
		else if (wr_acc && hit_set(waddr))
			irq_mask_r <= irq_mask_r | reg_wdata_in;
		else if (wr_acc && hit_clr(waddr))
			irq_mask_r <= irq_mask_r & ~reg_wdata_in;
	end

	// bit n of the mask gates event n, which sits at 0x100 + 4n
	always_ff @(posedge clk_in or negedge rst_sync_r) begin
		if (!rst_sync_r)
			irq_r <= 1'b0;
		else
			irq_r <= |(evt_flag_r & irq_mask_r);
	end

	// read mux; unmapped words and task words read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (is_evt)
			rdata_nxt[pti_pkg::FLAG_BIT] =
				evt_flag_r[pti_pkg::slot_of(waddr)];
		else if (is_gen)
			rdata_nxt = cfg_rdata_in;
		else if (hit_link(waddr))
			rdata_nxt = link_en_r;
		else if (hit_mask_grp(waddr))
			rdata_nxt = irq_mask_r;
	end

	// answer one cycle after the access; read data held until the next
	always_ff @(posedge clk_in or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			rdata_r <= 32'h0000_0000;
			ack_r   <= 1'b0;
		end else begin
			ack_r <= reg_sel_in;
			if (reg_sel_in && !reg_wr_in)
				rdata_r <= rdata_nxt;
		end
	end

	// generic region is handed to the peripheral's own logic
	assign cfg_wr_out    = wr_acc & is_gen;
	assign cfg_addr_out  = waddr;
	assign cfg_wdata_out = reg_wdata_in;

	assign reg_rdata_out = rdata_r;
	assign reg_ack_out   = ack_r;
	assign task_trig_out = task_trig_r;
	assign evt_gen_out   = evt_gen_r;
	assign irq_out       = irq_r;
	assign irq_num_out   = PERIPH_ID[4:0];

endmodule

// ==== bench/pti_core_props.sv ====
// concurrent checks on the register port and pulses of pti_core.
// assumes inputs move away from the rising edge of clk_in.
`timescale 1ns/1ps
module pti_core_props #(
	parameter logic [31:0] BASE_ADDR = 32'h4000_0000
) (
	input wire logic        clk_in, rst_b_in, reg_sel_in, reg_wr_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in, reg_rdata_out, cfg_rdata_in,
	input wire logic        reg_ack_out, irq_out, cfg_wr_out,
	input wire logic [31:0] task_sig_in, evt_sig_in, task_trig_out,
	input wire logic [31:0] evt_gen_out,
	input wire logic [4:0]  irq_num_out
);
	logic [31:0] evt_prev_r, task_prev_r;
	logic [4:0]  slot_r;
	wire logic [31:0] evt_chg = evt_sig_in ^ evt_prev_r;
	wire logic [31:0] task_chg = task_sig_in ^ task_prev_r;
	wire logic rd = reg_sel_in && !reg_wr_in;
	wire logic wrt = reg_sel_in && reg_wr_in;
	wire logic gen = reg_addr_in >= pti_pkg::GEN_LO_OFS &&
		reg_addr_in <= pti_pkg::GEN_HI_OFS;
	// previous toggle levels and addressed slot, to name the cause
	always_ff @(posedge clk_in) begin
		evt_prev_r <= evt_sig_in;
		task_prev_r <= task_sig_in;
		slot_r <= reg_addr_in[6:2];
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	chk_ack_one_cycle: assert property (
		reg_ack_out == $past(reg_sel_in)) else $error("ack timing");
	chk_task_write: assert property (
		wrt && reg_addr_in <= pti_pkg::TASK_HI_OFS && reg_wdata_in[0]
		|=> task_trig_out[slot_r]) else $error("task write lost");
	chk_task_toggle: assert property (
		|task_chg |=> (task_trig_out & $past(task_chg)) == $past(task_chg))
		else $error("task toggle lost");
	chk_evt_pulse: assert property (
		1 |=> evt_gen_out == $past(evt_chg)) else $error("event pulse");
	chk_irq_mask_off: assert property (
		wrt && reg_addr_in == pti_pkg::IRQ_CLR_OFS &&
		reg_wdata_in == 32'hffff_ffff |=> ##1 !irq_out)
		else $error("irq with mask clear");
	chk_zero_read: assert property (
		rd && (reg_addr_in <= pti_pkg::TASK_HI_OFS ||
		reg_addr_in > pti_pkg::GEN_HI_OFS) |=> reg_rdata_out == 32'h0)
		else $error("nonzero read");
	chk_gen_read: assert property (
		rd && gen |=> reg_rdata_out == $past(cfg_rdata_in))
		else $error("generic read");
	chk_cfg_strobe: assert property (
		cfg_wr_out == (wrt && gen)) else $error("generic strobe");
	chk_irq_number: assert property (
		irq_num_out == 5'((BASE_ADDR - pti_pkg::PERIPH_BASE) /
		pti_pkg::BLOCK_SIZE)) else $error("irq number");
	cover property (irq_out);
	cover property (|evt_gen_out && |task_trig_out);
	cover property (wrt && reg_addr_in == pti_pkg::IRQ_SET_OFS);
endmodule
bind pti_core pti_core_props #(.BASE_ADDR(BASE_ADDR)) u_props (.*);

// ==== bench/pti_cfg_model.sv ====
// small store standing in for the peripheral's own generic registers.
// assumes the core's combinational strobe, address and data outputs.
`timescale 1ns/1ps
module pti_cfg_model (
	input wire logic        clk_in,
	input wire logic        cfg_wr_in,
	input wire logic [11:0] cfg_addr_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic     [31:0] cfg_rdata_out
);
	logic [31:0] mem_r [4];
	// four words aliased over the region; enough to prove the path
	always_ff @(posedge clk_in)
		if (cfg_wr_in) mem_r[cfg_addr_in[3:2]] <= cfg_wdata_in;
	assign cfg_rdata_out = mem_r[cfg_addr_in[3:2]];
endmodule

// ==== bench/peripheral_task_event_interface_tb.sv ====
// self-checking bench for pti_core through its register port.
// assumes the one-edge ack and registered pulses of the core.
`timescale 1ns/1ps
module peripheral_task_event_interface_tb;
	logic clk_in = 0, rst_b_in = 0, sel = 0, wr = 0, ack, irq, cfg_wr;
	logic [11:0] addr = 12'h0, cfg_a;
	logic [31:0] wdata = 32'h0, task_sig = 32'h0, evt_sig = 32'h0;
	logic [31:0] trig, rdata, tto, ego, cfg_rd, cfg_wd;
	int n_errors = 0, n_checks = 0;
	always #50 clk_in = ~clk_in;
	pti_core u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_sel_in(sel),
		.reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .reg_ack_out(ack), .task_sig_in(task_sig),
		.evt_sig_in(evt_sig), .task_trig_out(tto), .evt_gen_out(ego),
		.irq_out(irq), .irq_num_out(), .cfg_wr_out(cfg_wr),
		.cfg_addr_out(cfg_a), .cfg_wdata_out(cfg_wd), .cfg_rdata_in(cfg_rd));
	pti_cfg_model u_cfg (.clk_in(clk_in), .cfg_wr_in(cfg_wr),
		.cfg_addr_in(cfg_a), .cfg_wdata_in(cfg_wd), .cfg_rdata_out(cfg_rd));
	task automatic conclude;
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one access; request held a full cycle, ack awaited a bounded time
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_in) #1;
		{sel, wr, addr, wdata} = {1'b1, w, a, d};
		@(posedge clk_in) #1;
		sel = 0;
		for (i = 0; i < 4 && ack !== 1'b1; i++) @(posedge clk_in) #1;
		if (i == 4) begin
			n_errors++;
			$display("wrong value at %0t: no ack", $time);
			conclude();
		end
		trig = tto;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		acc(0, a, 32'h0);
		chk(rdata, exp);
	endtask
	// toggle one event input, then look at its pulses one edge later
	task automatic evt_tog(input int n, input logic tsk);
		@(posedge clk_in) #1;
		evt_sig[n] = ~evt_sig[n];
		@(posedge clk_in) #1;
		chk(32'(ego[n]), 32'h1);
		chk(32'(tto[n]), 32'(tsk));
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		#1 rst_b_in = 1;
		repeat (3) @(posedge clk_in);
		rd(12'h300, 32'h0);
		rd(12'h200, 32'h0);
		rd(12'h17c, 32'h0);
		acc(1, 12'h304, 32'ha5a5_0f81);
		acc(1, 12'h308, 32'h0000_0f01);
		rd(12'h300, 32'ha5a5_0080);
		rd(12'h304, 32'ha5a5_0080);
		rd(12'h308, 32'ha5a5_0080);
		acc(1, 12'h200, 32'h0000_0008);
		rd(12'h200, 32'h0000_0008);
		evt_tog(3, 1);
		evt_tog(31, 0);
		evt_tog(31, 0);
		chk(32'(irq), 32'h1);
		acc(1, 12'h17c, 32'h1);
		rd(12'h17c, 32'h1);
		acc(1, 12'h17c, 32'h0);
		rd(12'h17c, 32'h0);
		chk(32'(irq), 32'h0);
		acc(1, 12'h304, 32'h8);
		@(posedge clk_in) #1;
		chk(32'(irq), 32'h1);
		acc(1, 12'h308, 32'hffff_ffff);
		rd(12'h300, 32'h0);
		chk(32'(irq), 32'h0);
		rd(12'h10c, 32'h1);
		acc(1, 12'h07c, 32'h1);
		chk(trig, 32'h8000_0000);
		acc(1, 12'h004, 32'h0);
		chk(trig, 32'h0);
		rd(12'h07c, 32'h0);
		@(posedge clk_in) #1;
		task_sig[7] = 1;
		@(posedge clk_in) #1;
		chk(tto, 32'h80);
		acc(1, 12'h300, 32'h0000_0010);
		rd(12'h304, 32'h0000_0010);
		acc(1, 12'h404, 32'hdead_beef);
		rd(12'h404, 32'hdead_beef);
		rd(12'h800, 32'h0);
		conclude();
	end
endmodule
